// file: sim/xwf_exec_tb.sv
// self-checking bench for the xor-to-file executor
`timescale 1ns/10ps
`include "xwf_cfg.svh"
`default_nettype none
module xwf_exec_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        exec_busy;
	logic [31:0] v;
	logic        e;
	int          mismatches = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          busy_cycles = 0;

	xwf_exec #(.PAGE_W(4)) xwf_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exec_busy(exec_busy));
	xwf_host xwf_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (exec_busy === 1'b1)
			busy_cycles <= busy_cycles + 1;
		if (cycles == 5000)
		begin
			mismatches++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xwf_host_inst.xfer(1'b1, a, d, v, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		xwf_host_inst.xfer(1'b0, a, 32'h0, v, e);
		check(name, v, exp);
	endtask

	task automatic mem(input logic [11:0] a, input logic [7:0] d);
		wr(`XWF_OFS_MADDR, {20'h0, a});
		wr(`XWF_OFS_MDATA, {24'h0, d});
	endtask

	task automatic memrd(input logic [11:0] a, input logic [7:0] exp, input string name);
		wr(`XWF_OFS_MADDR, {20'h0, a});
		rd(`XWF_OFS_MDATA, {24'h0, exp}, name);
	endtask

	// the read after the start stalls until the engine is back in idle
	task automatic run(input logic [15:0] op, input logic [31:0] stat_exp, input logic [31:0] busy_exp);
		int b0;
		wr(`XWF_OFS_EXSTAT, 32'h6);
		b0 = busy_cycles;
		wr(`XWF_OFS_INSTR, {16'h0, op});
		rd(`XWF_OFS_EXSTAT, stat_exp, "exstat outcome");
		check("busy cycles", busy_cycles - b0, busy_exp);
	endtask

	initial
	begin
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`XWF_OFS_WREG, 32'h0, "wreg reset");
		rd(`XWF_OFS_STATUS, 32'h0, "status reset");
		xwf_host_inst.xfer(1'b0, 8'h1C, 32'h0, v, e);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("unmapped data", v, 32'h0);
		// banked operand, written back, zero result
		wr(`XWF_OFS_PAGE, 32'h3);
		mem(12'h310, 8'hFF);
		mem(12'h010, 8'h55);
		wr(`XWF_OFS_WREG, 32'hFF);
		run(16'h1B10, 32'h4, 32'h4);
		rd(`XWF_OFS_WREG, 32'hFF, "wreg kept");
		memrd(12'h310, 8'h00, "banked file");
		memrd(12'h010, 8'h55, "page0 file");
		rd(`XWF_OFS_STATUS, 32'h4, "zero flag");
		// access bank low half, result to working register
		wr(`XWF_OFS_STATUS, 32'hB);
		mem(12'h005, 8'hAF);
		mem(12'h305, 8'h11);
		wr(`XWF_OFS_WREG, 32'hB5);
		run(16'h1805, 32'h4, 32'h4);
		rd(`XWF_OFS_WREG, 32'h1A, "wreg result");
		memrd(12'h005, 8'hAF, "file kept");
		rd(`XWF_OFS_STATUS, 32'hB, "flags clear");
		// access bank high half, negative result
		mem(12'hF85, 8'h80);
		wr(`XWF_OFS_WREG, 32'h1);
		run(16'h1A85, 32'h4, 32'h4);
		memrd(12'hF85, 8'h81, "high access");
		rd(`XWF_OFS_STATUS, 32'h1B, "neg flag");
		// undefined opcode: flagged after decode, nothing executed
		run(16'h1C05, 32'h2, 32'h1);
		rd(`XWF_OFS_STATUS, 32'h1B, "flags after bad op");
		memrd(12'hF85, 8'h81, "file after bad op");
		// reset while idle, after the last run
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`XWF_OFS_PAGE, 32'h0, "page reset");
		rd(`XWF_OFS_EXSTAT, 32'h0, "exstat reset");
		end_sim();
	end
endmodule // xwf_exec_tb
`default_nettype wire

// file: sim/xwf_host.sv
// apb master model standing in for the core that drives the executor
`timescale 1ns/10ps
`default_nettype none
module xwf_host
(
	// clock
	input  wire logic        pclk,
	// apb master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// request held from setup until the rising edge at which pready is seen high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
endmodule // xwf_host
`default_nettype wire

// file: src/xwf_alu.sv
// exclusive-or unit with negative and zero flag derivation
`timescale 1ns/10ps
`default_nettype none
module xwf_alu
	import xwf_pkg::*;
(
	// operands
	input  wire logic [7:0] acc_val,
	input  wire logic [7:0] file_val,
	// result with flags
	output var xwf_alu_t    alu_out
);

	always_comb
	begin
		alu_out.result = acc_val ^ file_val;
		alu_out.neg    = alu_out.result[7];
		alu_out.zero   = (alu_out.result == 8'h00);
	end

endmodule // xwf_alu
`default_nettype wire

// file: src/xwf_cfg.svh
// offsets, field positions, reset values and opcode constants of the xor-to-file executor
`ifndef XWF_CFG_SVH
`define XWF_CFG_SVH

`define XWF_OFS_INSTR      8'h00
`define XWF_OFS_WREG       8'h04
`define XWF_OFS_PAGE       8'h08
`define XWF_OFS_STATUS     8'h0C
`define XWF_OFS_MADDR      8'h10
`define XWF_OFS_MDATA      8'h14
`define XWF_OFS_EXSTAT     8'h18

`define XWF_OPC_HI         15:10
`define XWF_OPC_VAL        6'h06
`define XWF_DEST_BIT       9
`define XWF_ABANK_BIT      8
`define XWF_FILE_HI        7:0

`define XWF_ST_C           0
`define XWF_ST_DC          1
`define XWF_ST_Z           2
`define XWF_ST_OV          3
`define XWF_ST_N           4
`define XWF_ST_W           5

`define XWF_EX_BUSY        0
`define XWF_EX_BAD         1
`define XWF_EX_DONE        2

`define XWF_PAGE_W_DEF     4
`define XWF_ACCESS_SPLIT   8'h80
`define XWF_RST_WREG       8'h00
`define XWF_RST_PAGE       8'h00
`define XWF_RST_STATUS     5'h00
`define XWF_RST_INSTR      16'h0000

`endif

// file: src/xwf_exec.sv
// apb-reached executor of the exclusive_or_accumulator_file instruction with its data memory
// Function
// (RULE1) the result is the bitwise xor of the working register and the addressed file register.
// (RULE2) with the destination bit clear the result goes to the working register and the file stays.
// (RULE3) with the destination bit set the result is written back into the addressed file register.
// (RULE4) with the bank bit clear the operand lies in the fixed access bank, the page pointer ignored.
// (RULE5) with the bank bit set the operand address is formed with the memory_page_pointer page.
// (RULE6) only the negative and zero flags follow the result; other status flags keep their value.
// (RULE7) one word, one instruction cycle: decode, read, compute, write in four phases.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "xwf_cfg.svh"
`default_nettype none
module xwf_exec
	import xwf_pkg::*;
#(
	parameter int PAGE_W = `XWF_PAGE_W_DEF
)
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// core status
	output logic             exec_busy
);

	localparam int MEM_AW = PAGE_W + 8;
	localparam int MEM_DEPTH = 1 << MEM_AW;

	if (PAGE_W < 1 || PAGE_W > 8)
	begin : g_page_w_check
		$error("xwf_exec: PAGE_W must lie in 1..8");
	end

	// access bank: low half of page 0 and high half of the top page
	function automatic logic [MEM_AW-1:0] file_addr(input logic abank, input logic [PAGE_W-1:0] page,
		input logic [7:0] file);
		logic [PAGE_W-1:0] pg;
		pg = page;
		if (!abank)
			pg = (file >= `XWF_ACCESS_SPLIT) ? {PAGE_W{1'b1}} : {PAGE_W{1'b0}};
		file_addr = {pg, file};
	endfunction

	function automatic logic opc_match(input logic [15:0] opc);
		opc_match = (opc[`XWF_OPC_HI] == `XWF_OPC_VAL);
	endfunction

	logic [7:0]        mem [MEM_DEPTH];
	logic [7:0]        wreg_reg;
	logic [PAGE_W-1:0] page_reg;
	logic [4:0]        status_reg;
	logic [15:0]       instr_reg;
	logic [MEM_AW-1:0] maddr_reg;
	logic              bad_reg;
	logic              done_reg;
	xwf_phase_t        phase_reg;
	xwf_instr_t        dec_reg;
	logic [MEM_AW-1:0] addr_reg;
	logic [7:0]        operand_reg;
	xwf_alu_t          alu_reg;
	xwf_alu_t          alu_val;
	logic [31:0]       prdata_reg;
	logic              fresh_reg;
	logic [31:0]       rd_value;
	logic              addr_ok;
	logic              wr_acc;
	logic              start;

	assign exec_busy = (phase_reg != XWF_IDLE);
	assign wr_acc    = psel && penable && pready && pwrite;
	assign start     = wr_acc && (paddr == `XWF_OFS_INSTR);
	assign prdata    = prdata_reg;

	// address decode shared by read data and error answer
	always_comb
	begin
		addr_ok  = 1'b1;
		rd_value = 32'h0000_0000;
		unique case (paddr)
			`XWF_OFS_INSTR:  rd_value[15:0] = instr_reg;
			`XWF_OFS_WREG:   rd_value[7:0] = wreg_reg;
			`XWF_OFS_PAGE:   rd_value[PAGE_W-1:0] = page_reg;
			`XWF_OFS_STATUS: rd_value[4:0] = status_reg;
			`XWF_OFS_MADDR:  rd_value[MEM_AW-1:0] = maddr_reg;
			`XWF_OFS_MDATA:  rd_value[7:0] = mem[maddr_reg];
			`XWF_OFS_EXSTAT: rd_value[2:0] = {done_reg, bad_reg, exec_busy};
			default:         addr_ok = 1'b0;
		endcase
	end

	// read data sampled while idle; an access waits until execution is over, so it never sees
	// a half-finished instruction and never races the engine for memory or registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= 32'h0000_0000;
			fresh_reg  <= 1'b0;
		end
		else if (psel && !(penable && pready))
		begin
			prdata_reg <= rd_value;
			fresh_reg  <= !exec_busy;
		end
		else
		begin
			fresh_reg <= 1'b0;
		end
	end

	assign pready  = psel && penable && fresh_reg;
	assign pslverr = pready && !addr_ok;

	// instruction cycle sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_reg <= XWF_IDLE;
		else
		begin
			unique case (phase_reg)
				XWF_IDLE: if (start && addr_ok) phase_reg <= XWF_Q1; // [RULE7]
				XWF_Q1:   phase_reg <= opc_match(instr_reg) ? XWF_Q2 : XWF_IDLE; // [RULE7]
				XWF_Q2:   phase_reg <= XWF_Q3;
				XWF_Q3:   phase_reg <= XWF_Q4;
				XWF_Q4:   phase_reg <= XWF_IDLE;
				default:  phase_reg <= XWF_IDLE;
			endcase
		end
	end

	// q1 decode and operand address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dec_reg  <= '0;
			addr_reg <= '0;
		end
		else if (phase_reg == XWF_Q1)
		begin
			dec_reg.dest  <= instr_reg[`XWF_DEST_BIT];
			dec_reg.abank <= instr_reg[`XWF_ABANK_BIT];
			dec_reg.file  <= instr_reg[`XWF_FILE_HI];
			addr_reg      <= file_addr(instr_reg[`XWF_ABANK_BIT], page_reg, instr_reg[`XWF_FILE_HI]); // [RULE4] [RULE5]
		end
	end

	// q2 operand read, q3 compute
	xwf_alu xwf_alu_inst (
		.acc_val  (wreg_reg),
		.file_val (operand_reg),
		.alu_out  (alu_val)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			operand_reg <= 8'h00;
			alu_reg     <= '0;
		end
		else
		begin
			if (phase_reg == XWF_Q2)
				operand_reg <= mem[addr_reg];
			if (phase_reg == XWF_Q3)
				alu_reg <= alu_val; // [RULE1]
		end
	end

	// data memory: software port while idle, destination write in q4
	always_ff @(posedge pclk)
	begin
		if (phase_reg == XWF_Q4 && dec_reg.dest)
			mem[addr_reg] <= alu_reg.result; // [RULE3]
		else if (wr_acc && paddr == `XWF_OFS_MDATA)
			mem[maddr_reg] <= pwdata[7:0];
	end

	// working register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wreg_reg <= `XWF_RST_WREG;
		else if (phase_reg == XWF_Q4 && !dec_reg.dest)
			wreg_reg <= alu_reg.result; // [RULE2]
		else if (wr_acc && paddr == `XWF_OFS_WREG)
			wreg_reg <= pwdata[7:0];
	end

	// status: engine touches only n and z
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_reg <= `XWF_RST_STATUS;
		else if (phase_reg == XWF_Q4)
		begin
			status_reg[`XWF_ST_N] <= alu_reg.neg; // [RULE6]
			status_reg[`XWF_ST_Z] <= alu_reg.zero; // [RULE6]
		end
		else if (wr_acc && paddr == `XWF_OFS_STATUS)
			status_reg <= pwdata[4:0];
	end

	// software-written configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			page_reg  <= PAGE_W'(`XWF_RST_PAGE);
			maddr_reg <= '0;
			instr_reg <= `XWF_RST_INSTR;
		end
		else if (wr_acc)
		begin
			if (paddr == `XWF_OFS_PAGE)
				page_reg <= pwdata[PAGE_W-1:0];
			if (paddr == `XWF_OFS_MADDR)
				maddr_reg <= pwdata[MEM_AW-1:0];
			if (paddr == `XWF_OFS_INSTR)
				instr_reg <= pwdata[15:0];
		end
	end

	// sticky outcome flags, write one to clear; a set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bad_reg  <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			if (phase_reg == XWF_Q1 && !opc_match(instr_reg))
				bad_reg <= 1'b1;
			else if (wr_acc && paddr == `XWF_OFS_EXSTAT && pwdata[`XWF_EX_BAD])
				bad_reg <= 1'b0;
			if (phase_reg == XWF_Q4)
				done_reg <= 1'b1;
			else if (wr_acc && paddr == `XWF_OFS_EXSTAT && pwdata[`XWF_EX_DONE])
				done_reg <= 1'b0;
		end
	end

	// checks
	logic [7:0] file_now;
	assign file_now = mem[addr_reg];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	xor_result_a: assert property (phase_reg == XWF_Q3 |=> alu_reg.result == $past(wreg_reg ^ operand_reg)) // [RULE1]
		else $error("xor result does not match operands");
	dest_w_a: assert property (phase_reg == XWF_Q4 && !dec_reg.dest
		|=> wreg_reg == $past(alu_reg.result) && file_now == $past(file_now)) // [RULE2]
		else $error("working register destination wrong");
	dest_file_a: assert property (phase_reg == XWF_Q4 && dec_reg.dest
		|=> file_now == $past(alu_reg.result) && $stable(wreg_reg)) // [RULE3]
		else $error("file destination wrong");
	access_bank_a: assert property (phase_reg == XWF_Q2 && !dec_reg.abank
		|-> addr_reg == {{PAGE_W{dec_reg.file[7]}}, dec_reg.file}) // [RULE4]
		else $error("access bank address wrong");
	page_sel_a: assert property (phase_reg == XWF_Q2 && dec_reg.abank |-> addr_reg == {page_reg, dec_reg.file}) // [RULE5]
		else $error("paged address wrong");
	flags_nz_a: assert property (phase_reg == XWF_Q4 |=> status_reg[`XWF_ST_N] == $past(alu_reg.result[7])
		&& status_reg[`XWF_ST_Z] == ($past(alu_reg.result) == 8'h00)) // [RULE6]
		else $error("n or z flag wrong");
	flags_keep_a: assert property (phase_reg == XWF_Q4 |=> status_reg[`XWF_ST_OV] == $past(status_reg[`XWF_ST_OV])
		&& status_reg[1:0] == $past(status_reg[1:0])) // [RULE6]
		else $error("unrelated flag changed");
	phase_seq_a: assert property (phase_reg == XWF_Q1 && opc_match(instr_reg)
		|=> phase_reg == XWF_Q2 ##1 phase_reg == XWF_Q3 ##1 phase_reg == XWF_Q4 ##1 phase_reg == XWF_IDLE) // [RULE7]
		else $error("instruction cycle phases out of order");
	start_a: assert property (start && !exec_busy |=> phase_reg == XWF_Q1) // [RULE7]
		else $error("instruction write did not start decode");
	bad_op_a: assert property (phase_reg == XWF_Q1 && !opc_match(instr_reg)
		|=> bad_reg && phase_reg == XWF_IDLE) // [RULE7]
		else $error("undefined opcode not flagged");
	done_set_a: assert property (phase_reg == XWF_Q4 |=> done_reg) // [RULE7]
		else $error("done flag not set after write phase");
	// a stalled access must not complete while the engine owns memory and registers
	bus_stall_a: assert property (exec_busy |-> !pready) // [RULE7]
		else $error("bus access completed during execution");

	exec_w_c: cover property (phase_reg == XWF_Q4 && !dec_reg.dest);
	exec_f_c: cover property (phase_reg == XWF_Q4 && dec_reg.dest && dec_reg.abank);
	access_c: cover property (phase_reg == XWF_Q2 && !dec_reg.abank && dec_reg.file[7]);
	bad_c:    cover property (phase_reg == XWF_Q1 && !opc_match(instr_reg));
	exec_n_c: cover property (phase_reg == XWF_Q4 && alu_reg.neg);

endmodule // xwf_exec
`default_nettype wire

// file: src/xwf_pkg.sv
// types shared by the xor-to-file executor
`default_nettype none
package xwf_pkg;

	typedef enum logic [2:0] {
		XWF_IDLE = 3'b000,
		XWF_Q1   = 3'b001,
		XWF_Q2   = 3'b010,
		XWF_Q3   = 3'b011,
		XWF_Q4   = 3'b100
	} xwf_phase_t;

	typedef struct packed {
		logic       dest;
		logic       abank;
		logic [7:0] file;
	} xwf_instr_t;

	typedef struct packed {
		logic [7:0] result;
		logic       neg;
		logic       zero;
	} xwf_alu_t;

endpackage
`default_nettype wire
